// File: hdl/pwl_regs.sv
// Prefetchable window base and limit register bank with window decision
//
// Overview of operation
// R1: Writable 12-bit limit in bits 31:20 at 0x24, reset zero.
// R2: Window top takes its low 20 address bits as all ones.
// R3: Bits 19:16 at 0x24 always read 0x1; writes ignored.
// R4: Window aligned and sized in 1MB steps; low bits never stored.
// R5: Writable 32-bit register at 0x28 gives bottom bits 63:32, reset zero.
// R6: Writable 32-bit register at 0x2C gives top bits 63:32, reset zero.
// R7: Base and limit decide forwarding of memory reads and writes.
// R8: Upper half at 0x24 resets 0x0001, written under byte enables 3, 2.
// R9: Targets in the window should tolerate extra reads harmlessly.
// R10: Software programs limit and upper registers before using the window.
// R11: Base bits 15:4 at 0x24 give bottom bits 31:20, low bits zero.
// R12: Address inside when bottom <= address <= top, all 64 bits.
`timescale 1ns/1ps
module pwl_regs (
	input wire logic clock, // 40 MHz bus clock
	input wire logic sys_rst, // Synchronous reset, active high
	input wire pwl_pkg::pwl_cfg_req_type cfg_req, // Configuration access
	output logic [31:0] cfg_rdata, // Read data
	output logic cfg_rvalid, // Read data valid pulse
	input wire pwl_pkg::pwl_lookup_type lookup, // Address to decide on
	output logic fwd_hit, // Address falls in window
	output logic fwd_hit_valid, // Decision valid pulse
	output logic [63:0] window_bottom, // Assembled bottom address
	output logic [63:0] window_top // Assembled top address
);
	pwl_pkg::pwl_state_type state_reg;
	pwl_pkg::pwl_state_type state_next;
	logic [31:0] lane_mask;
	logic [31:0] read_word;
	logic [31:0] low_dword;
	logic [63:0] bottom_addr;
	logic [63:0] top_addr;
	logic in_window;
	logic sel_low;
	logic sel_base_high;
	logic sel_limit_high;

	// Byte lane write mask from active-low enables
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane++) begin : g_lane
			assign lane_mask[8*lane +: 8] = {8{~cfg_req.be_n[lane]}};
		end
	endgenerate

	// Address decode
	assign sel_low = cfg_req.addr == pwl_pkg::PWL_OFS_BASE_LIMIT_LOW;
	assign sel_base_high = cfg_req.addr == pwl_pkg::PWL_OFS_BASE_HIGH;
	assign sel_limit_high = cfg_req.addr == pwl_pkg::PWL_OFS_LIMIT_HIGH;

	// Window bounds; bits below 1MB are constants, never storage
	assign bottom_addr = {state_reg.prefetch_base_high_bits,
		state_reg.prefetch_base_field,
		pwl_pkg::PWL_GRANULE_ZERO}; // [R4] [R11] [R5]
	assign top_addr = {state_reg.prefetch_limit_high_bits,
		state_reg.prefetch_limit_field,
		pwl_pkg::PWL_GRANULE_ONES}; // [R2] [R4] [R6]

	// Inclusive comparison against the assembled bounds
	pwl_window_match u_match (
		.bottom(bottom_addr),
		.top(top_addr),
		.addr(lookup.addr),
		.in_window(in_window)
	);

	// Dword at the low offset with the read-only capability codes
	assign low_dword = {state_reg.prefetch_limit_field,
		pwl_pkg::PWL_WIDE_ADDR_CAP,
		state_reg.prefetch_base_field,
		pwl_pkg::PWL_WIDE_ADDR_CAP}; // [R3]

	// Read multiplexer; unmapped offsets read as zero
	always_comb begin
		case (cfg_req.addr)
			pwl_pkg::PWL_OFS_BASE_LIMIT_LOW: read_word = low_dword;
			pwl_pkg::PWL_OFS_BASE_HIGH: begin
				read_word = state_reg.prefetch_base_high_bits;
			end
			pwl_pkg::PWL_OFS_LIMIT_HIGH: begin
				read_word = state_reg.prefetch_limit_high_bits;
			end
			default: read_word = 32'h00000000;
		endcase
	end

	// Next-state logic for the whole bank
	always_comb begin
		state_next = state_reg;
		state_next.rvalid = 1'b0;
		state_next.hit_valid = 1'b0;
		// Limit field under lanes 3 and 2, base field under lanes 1 and 0; capability bits not stored
		if (cfg_req.wr && sel_low) begin
			if (!cfg_req.be_n[3]) begin
				state_next.prefetch_limit_field[11:4] =
					cfg_req.wdata[31:24]; // [R1] [R8]
			end
			if (!cfg_req.be_n[2]) begin
				state_next.prefetch_limit_field[3:0] =
					cfg_req.wdata[23:20]; // [R1] [R8] [R3]
			end
			if (!cfg_req.be_n[1]) begin
				state_next.prefetch_base_field[11:4] =
					cfg_req.wdata[15:8]; // [R11]
			end
			if (!cfg_req.be_n[0]) begin
				state_next.prefetch_base_field[3:0] =
					cfg_req.wdata[7:4]; // [R11]
			end
		end
		// Upper base bits, every lane writable
		if (cfg_req.wr && sel_base_high) begin
			state_next.prefetch_base_high_bits =
				(state_reg.prefetch_base_high_bits & ~lane_mask) |
				(cfg_req.wdata & lane_mask); // [R5]
		end
		// Upper limit bits, every lane writable
		if (cfg_req.wr && sel_limit_high) begin
			state_next.prefetch_limit_high_bits =
				(state_reg.prefetch_limit_high_bits & ~lane_mask) |
				(cfg_req.wdata & lane_mask); // [R6]
		end
		// Registered read answer
		if (cfg_req.rd) begin
			state_next.rdata = read_word;
			state_next.rvalid = 1'b1;
		end
		// Forwarding decision, one cycle after the lookup
		if (lookup.valid) begin
			state_next.hit = in_window; // [R7] [R12]
			state_next.hit_valid = 1'b1;
		end
		// Reset values
		if (sys_rst) begin
			state_next.prefetch_limit_field = pwl_pkg::PWL_RST_FIELD; // [R1]
			state_next.prefetch_base_field = pwl_pkg::PWL_RST_FIELD;
			state_next.prefetch_base_high_bits = pwl_pkg::PWL_RST_HIGH;
			state_next.prefetch_limit_high_bits = pwl_pkg::PWL_RST_HIGH;
			state_next.rdata = pwl_pkg::PWL_RST_RDATA;
			state_next.rvalid = 1'b0;
			state_next.hit = 1'b0;
			state_next.hit_valid = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clock) begin
		state_reg <= state_next;
	end

	// Outputs straight from state
	assign cfg_rdata = state_reg.rdata;
	assign cfg_rvalid = state_reg.rvalid;
	assign fwd_hit = state_reg.hit;
	assign fwd_hit_valid = state_reg.hit_valid;
	assign window_bottom = bottom_addr;
	assign window_top = top_addr;

	// Checks on the register bank
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	// Limit field clears after reset
	chk_limit_reset: assert property ( // [R1]
		@(posedge clock) $past(sys_rst) |->
			state_reg.prefetch_limit_field == 12'h000)
		else $error("limit field not zero after reset");

	// Upper halves clear after reset
	chk_high_reset: assert property ( // [R5]
		@(posedge clock) $past(sys_rst) |->
			(state_reg.prefetch_base_high_bits == 32'h00000000) &&
			(state_reg.prefetch_limit_high_bits == 32'h00000000))
		else $error("upper registers not zero after reset");

	// Limit lane write takes the written byte
	chk_limit_write: assert property ( // [R1]
		cfg_req.wr && sel_low && !cfg_req.be_n[3] |=>
			state_reg.prefetch_limit_field[11:4] == $past(cfg_req.wdata[31:24]))
		else $error("limit field byte not written");

	// Limit holds when lanes 3 and 2 are off
	chk_limit_lanes: assert property ( // [R8]
		cfg_req.wr && sel_low && cfg_req.be_n[3] && cfg_req.be_n[2] |=>
			$stable(state_reg.prefetch_limit_field))
		else $error("limit changed without its byte enables");

	// Top low bits all ones, bottom low bits zero
	chk_granule_bits: assert property ( // [R2]
		(window_top[19:0] == 20'hFFFFF) && (window_bottom[19:0] == 20'h00000))
		else $error("window bounds not 1MB aligned");

	// Capability reads back as one in both halves
	chk_cap_read: assert property ( // [R3]
		cfg_req.rd && sel_low |=> cfg_rvalid ##0
			(cfg_rdata[19:16] == 4'h1) && (cfg_rdata[3:0] == 4'h1))
		else $error("capability code wrong on read");

	// Base upper write reaches the bottom bound
	chk_base_high: assert property ( // [R5]
		cfg_req.wr && sel_base_high && (cfg_req.be_n == 4'h0) |=>
			window_bottom[63:32] == $past(cfg_req.wdata))
		else $error("base upper bits not written");

	// Limit upper write reaches the top bound
	chk_limit_high: assert property ( // [R6]
		cfg_req.wr && sel_limit_high && (cfg_req.be_n == 4'h0) |=>
			window_top[63:32] == $past(cfg_req.wdata))
		else $error("limit upper bits not written");

	// Decision matches the inclusive bounds of the same cycle
	chk_hit_bounds: assert property ( // [R12]
		lookup.valid |=> fwd_hit_valid ##0
			fwd_hit == (($past(lookup.addr) >= $past(window_bottom)) &&
			($past(lookup.addr) <= $past(window_top))))
		else $error("forwarding decision wrong");

	// No decision pulse without a lookup
	chk_hit_pulse: assert property ( // [R7]
		!lookup.valid |=> !fwd_hit_valid)
		else $error("decision pulse without lookup");

	// Main scenarios
	cov_limit_write: cover property (cfg_req.wr && sel_low &&
		!cfg_req.be_n[3]);
	cov_hit: cover property (fwd_hit_valid && fwd_hit);
	cov_miss: cover property (fwd_hit_valid && !fwd_hit);
	cov_read_low: cover property (cfg_req.rd && sel_low ##1 cfg_rvalid);
endmodule : pwl_regs

// File: hdl/pwl_window_match.sv
// Inclusive 64-bit window comparator
`timescale 1ns/1ps
module pwl_window_match (
	input wire logic [63:0] bottom, // Assembled window bottom
	input wire logic [63:0] top, // Assembled window top
	input wire logic [63:0] addr, // Address under test
	output logic in_window // Address lies within bounds
);
	// Both bounds inclusive
	assign in_window = (addr >= bottom) && (addr <= top);
endmodule : pwl_window_match

// File: include/pwl_pkg.sv
// Package with offsets, field layouts, reset values and carriers
package pwl_pkg;
	// Dword offsets of the configuration registers
	localparam logic [7:0] PWL_OFS_BASE_LIMIT_LOW = 8'h24;
	localparam logic [7:0] PWL_OFS_BASE_HIGH = 8'h28;
	localparam logic [7:0] PWL_OFS_LIMIT_HIGH = 8'h2C;

	// Field positions inside the dword at the low-limit offset
	localparam int PWL_LIMIT_LSB = 20;
	localparam int PWL_LIMIT_MSB = 31;
	localparam int PWL_CAP_HI_LSB = 16;
	localparam int PWL_CAP_HI_MSB = 19;
	localparam int PWL_BASE_LSB = 4;
	localparam int PWL_BASE_MSB = 15;
	localparam int PWL_CAP_LO_LSB = 0;
	localparam int PWL_CAP_LO_MSB = 3;

	// Width of the address bits below the 1MB granule
	localparam int PWL_GRANULE_BITS = 20;
	localparam logic [19:0] PWL_GRANULE_ZERO = 20'h00000;
	localparam logic [19:0] PWL_GRANULE_ONES = 20'hFFFFF;

	// Reset values
	localparam logic [15:0] PWL_RST_LIMIT_LOW = 16'h0001;
	localparam logic [15:0] PWL_RST_BASE_LOW = 16'h0001;
	localparam logic [11:0] PWL_RST_FIELD = 12'h000;
	localparam logic [31:0] PWL_RST_HIGH = 32'h00000000;
	localparam logic [31:0] PWL_RST_RDATA = 32'h00000000;

	// Read-only 64-bit addressing capability code
	localparam logic [3:0] PWL_WIDE_ADDR_CAP = 4'h1;

	// Configuration access from the primary bus, byte enables active low
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [3:0] be_n;
		logic [31:0] wdata;
	} pwl_cfg_req_type;

	// Address presented for the forwarding decision
	typedef struct packed {
		logic valid;
		logic [63:0] addr;
	} pwl_lookup_type;

	// Complete state of the register bank
	typedef struct packed {
		logic [11:0] prefetch_limit_field;
		logic [11:0] prefetch_base_field;
		logic [31:0] prefetch_base_high_bits;
		logic [31:0] prefetch_limit_high_bits;
		logic [31:0] rdata;
		logic rvalid;
		logic hit;
		logic hit_valid;
	} pwl_state_type;
endpackage : pwl_pkg

// File: test/pwl_host.sv
// Configuration host model driving register accesses and lookups
`timescale 1ns/1ps
module pwl_host (
	input wire logic clock, // Bus clock
	output pwl_pkg::pwl_cfg_req_type cfg_req, // Configuration access
	output pwl_pkg::pwl_lookup_type lookup, // Address to decide on
	input wire logic [31:0] cfg_rdata, // Read data
	input wire logic cfg_rvalid, // Read data valid
	input wire logic fwd_hit, // Window decision
	input wire logic fwd_hit_valid // Decision valid
);
	// Idle bus from time zero
	initial begin
		cfg_req = '{1'h0, 1'h0, 8'h00, 4'hF, 32'h0};
		lookup = '{1'h0, 64'h0};
	end

	// One write, strobe for one cycle, lines scrambled after release
	task automatic cfg_write(input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		@(posedge clock);
		#1;
		cfg_req = '{1'h1, 1'h0, a, be, d};
		@(posedge clock);
		#1;
		cfg_req = '{1'h0, 1'h0, ~a, ~be, ~d};
	endtask : cfg_write

	// One read, answer taken the cycle after; reads have no side effects
	task automatic cfg_read(input logic [7:0] a, output logic [31:0] d,
		output logic v);
		@(posedge clock);
		#1;
		cfg_req = '{1'h0, 1'h1, a, 4'h0, cfg_req.wdata};
		@(posedge clock);
		#1;
		cfg_req.rd = 1'h0;
		cfg_req.addr = ~a;
		d = cfg_rdata;
		v = cfg_rvalid;
	endtask : cfg_read

	// One lookup, only after the window is programmed
	task automatic probe(input logic [63:0] a, output logic h, output logic v);
		@(posedge clock);
		#1;
		lookup = '{1'h1, a};
		@(posedge clock);
		#1;
		lookup = '{1'h0, ~a};
		h = fwd_hit;
		v = fwd_hit_valid;
	endtask : probe
endmodule : pwl_host

// File: test/pwl_regs_test.sv
// Self-checking bench for the prefetch window register bank
`timescale 1ns/1ps
module pwl_regs_test;
	localparam logic [7:0] A_LOW = pwl_pkg::PWL_OFS_BASE_LIMIT_LOW;
	localparam logic [7:0] A_BHI = pwl_pkg::PWL_OFS_BASE_HIGH;
	localparam logic [7:0] A_LHI = pwl_pkg::PWL_OFS_LIMIT_HIGH;
	logic clock = 1'h0;
	logic sys_rst = 1'h1;
	pwl_pkg::pwl_cfg_req_type cfg_req;
	pwl_pkg::pwl_lookup_type lookup;
	logic [31:0] cfg_rdata;
	logic cfg_rvalid;
	logic fwd_hit;
	logic fwd_hit_valid;
	logic [63:0] window_bottom;
	logic [63:0] window_top;
	int fails = 0;
	int checked = 0;
	int cycles = 0;
	logic [31:0] rd_data;
	logic rd_ok;
	logic hit;
	logic hit_ok;
	logic [63:0] probe_addr [4] = '{64'h00000001_ABBFFFFF,
		64'h00000001_ABC00000, 64'h00000002_123FFFFF, 64'h00000002_12400000};
	logic probe_hit [4] = '{1'h0, 1'h1, 1'h1, 1'h0};

	// Clock at 40 MHz
	always #12.5 clock = ~clock;

	pwl_regs DUT (.clock(clock), .sys_rst(sys_rst), .cfg_req(cfg_req),
		.cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .lookup(lookup),
		.fwd_hit(fwd_hit), .fwd_hit_valid(fwd_hit_valid),
		.window_bottom(window_bottom), .window_top(window_top));

	pwl_host host (.clock(clock), .cfg_req(cfg_req), .lookup(lookup),
		.cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .fwd_hit(fwd_hit),
		.fwd_hit_valid(fwd_hit_valid));

	// Compare and count
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask : check

	// Read and compare data together with its valid pulse
	task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
		host.cfg_read(a, rd_data, rd_ok);
		check({31'h0, rd_ok, rd_data}, {32'h1, exp});
	endtask : read_check

	// Counts and verdict
	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out

	// Hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 500) begin
			fails++;
			close_out();
		end
	end

	// Test sequence
	initial begin
		repeat (2) @(posedge clock);
		#1;
		sys_rst = 1'h0;
		read_check(A_LOW, 32'h00010001);
		read_check(A_BHI, 32'h00000000);
		read_check(A_LHI, 32'h00000000);
		check(window_top, 64'h00000000_000FFFFF);
		check(window_bottom, 64'h0);
		$display("Test reset values done");
		host.cfg_write(A_LOW, 4'h0, 32'hFFFFFFFF);
		read_check(A_LOW, 32'hFFF1FFF1);
		host.cfg_write(A_LOW, 4'h3, 32'h12345678);
		read_check(A_LOW, 32'h1231FFF1);
		host.cfg_write(A_LOW, 4'hC, 32'h0000ABC0);
		read_check(A_LOW, 32'h1231ABC1);
		$display("Test low dword lanes done");
		host.cfg_write(A_BHI, 4'h0, 32'h00000001);
		host.cfg_write(A_LHI, 4'h0, 32'h000000FF);
		host.cfg_write(A_LHI, 4'hE, 32'hFFFFFF02);
		read_check(A_BHI, 32'h00000001);
		read_check(A_LHI, 32'h00000002);
		check(window_bottom, 64'h00000001_ABC00000);
		check(window_top, 64'h00000002_123FFFFF);
		$display("Test upper registers done");
		for (int i = 0; i < 4; i++) begin
			host.probe(probe_addr[i], hit, hit_ok);
			check({62'h0, hit_ok, hit}, {62'h0, 1'h1, probe_hit[i]});
		end
		$display("Test window edges done");
		// Reset in mid-run returns programmed fields to reset values
		@(posedge clock);
		#1;
		sys_rst = 1'h1;
		repeat (2) @(posedge clock);
		#1;
		sys_rst = 1'h0;
		read_check(A_LOW, 32'h00010001);
		read_check(A_LHI, 32'h00000000);
		check(window_bottom, 64'h0);
		$display("Test mid-run reset done");
		close_out();
	end
endmodule : pwl_regs_test
